/* src/bszf_defs.vh */
// Constants shared by the back-EMF sampling and Z filter block.
`ifndef BSZF_DEFS_VH
`define BSZF_DEFS_VH
`define BSZF_ADDR_W          8
`define BSZF_ADDR_CFG        8'h00
`define BSZF_ADDR_PAR        8'h04
`define BSZF_ADDR_ZFR        8'h08
`define BSZF_CFG_RST         8'h02
`define BSZF_PAR_RST         8'h00
`define BSZF_ZFR_RST         8'h0F
`define BSZF_CFG_FLAG        3
`define BSZF_CFG_MASK        2
`define BSZF_CFG_DELAY       7:4
`define BSZF_CFG_LOW         2:0
`define BSZF_CFG_DIV         1:0
`define BSZF_PAR_TACHO       7:6
`define BSZF_PAR_PARITY      5:0
`define BSZF_ZFR_COUNT       7:4
`define BSZF_ZFR_BLANK       3:0
`define BSZF_RESP_OKAY       2'h0
`define BSZF_RESP_SLVERR     2'h2
`define BSZF_DIV1            2'h0
`define BSZF_DIV2            2'h1
`define BSZF_TACHO_POSITION  2'h0
`define BSZF_PERIPH_KHZ      4000
`define BSZF_DELAY_STEP_NS   2500
`define BSZF_WIN_FINE_NS     5000
`define BSZF_WIN_COARSE_NS   20000
`define BSZF_WIN_BASE_NS     40000
`define BSZF_DELAY_STEP_TICKS ((`BSZF_DELAY_STEP_NS * `BSZF_PERIPH_KHZ + 999999) / 1000000)
`define BSZF_WIN_FINE_TICKS  ((`BSZF_WIN_FINE_NS * `BSZF_PERIPH_KHZ + 999999) / 1000000)
`define BSZF_WIN_COARSE_TICKS ((`BSZF_WIN_COARSE_NS * `BSZF_PERIPH_KHZ + 999999) / 1000000)
`define BSZF_WIN_BASE_TICKS  ((`BSZF_WIN_BASE_NS * `BSZF_PERIPH_KHZ + 999999) / 1000000)
`define BSZF_FINE_CODES      4'h8
`define BSZF_WIN_CODE_BIAS   4'h7
`endif

/* src/bszf_tick_div.v */
// Peripheral clock enable divider of the motor clock.
`default_nettype none
`include "bszf_defs.vh"
module bszf_tick_div (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [1:0] div_sel,
  output reg        tick_ff
);
  reg  [1:0] cnt_ff;
  reg  [1:0] nxt_cnt;
  reg        nxt_tick;

  always @* begin
    nxt_cnt = cnt_ff + 2'h1;
    nxt_tick = 1'b0;
    case (div_sel)
      `BSZF_DIV1: begin
        nxt_tick = 1'b1;
        nxt_cnt = 2'h0;
      end
      `BSZF_DIV2: begin
        nxt_tick = cnt_ff[0];
        nxt_cnt = {1'b0, ~cnt_ff[0]};
      end
      default: begin
        nxt_tick = (cnt_ff == 2'h3);
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 2'h0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end
endmodule
`default_nettype wire

/* src/bszf_top.v */
// Back-EMF sampling configuration, Z event filter and output parity with an AXI4-Lite register slave.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`default_nettype none
`include "bszf_defs.vh"
module bszf_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        pwm_on,
  input  wire        sample_clk_tick,
  input  wire        z_sample_at_pwm,
  input  wire        z_compare_pin,
  input  wire        d_event,
  input  wire        sensor_mode,
  input  wire        independent_phase_mode,
  input  wire [5:0]  chan_drive,
  output reg  [5:0]  chan_out_ff,
  output reg         z_event_ff,
  output reg         sampling_out_irq_ff,
  output reg  [1:0]  tacho_edge_sel_ff,
  output reg         speed_sensor_mode_ff,
  output reg         periph_tick_out_ff
);
  reg  [7:0]  cfg_ff;
  reg  [7:0]  par_ff;
  reg  [7:0]  zfr_ff;
  reg  [7:0]  aw_addr_ff;
  reg         aw_have_ff;
  reg  [7:0]  w_data_ff;
  reg         w_strb_ff;
  reg         w_have_ff;
  reg         z_meta_ff;
  reg         z_sync_ff;
  reg         pwm_prev_ff;
  reg  [7:0]  delay_cnt_ff;
  reg         delay_run_ff;
  reg         delay_done_ff;
  reg  [9:0]  blank_cnt_ff;
  reg  [4:0]  z_run_ff;
  reg         z_armed_ff;
  wire        periph_tick;
  wire [3:0]  ton_sample_delay;
  wire        sampling_out_mask;
  wire [3:0]  z_sample_count;
  wire [3:0]  d_to_z_blank_len;
  wire        pwm_rise;
  wire        pwm_fall;
  wire        delay_expire;
  wire        sample_late;
  wire        z_sample_strobe;
  wire        blanked;
  wire        z_hit;
  wire        wr_go;
  wire        wr_cfg;
  wire        flag_set;
  reg  [7:0]  nxt_cfg;
  reg  [4:0]  nxt_z_run;
  reg  [31:0] nxt_rdata;
  reg  [1:0]  nxt_rresp;

  function [7:0] delay_ticks;
    input [3:0] code;
    integer t;
    begin
      t = code * `BSZF_DELAY_STEP_TICKS;
      delay_ticks = t[7:0];
    end
  endfunction

  function [9:0] win_ticks;
    input [3:0] code;
    integer t;
    begin
      if (code < `BSZF_FINE_CODES) begin
        t = (code + 1) * `BSZF_WIN_FINE_TICKS;
      end else begin
        t = `BSZF_WIN_BASE_TICKS + (code - `BSZF_WIN_CODE_BIAS) * `BSZF_WIN_COARSE_TICKS;
      end
      win_ticks = t[9:0];
    end
  endfunction

  function reg_mapped;
    input [7:0] addr;
    begin
      reg_mapped = (addr == `BSZF_ADDR_CFG) || (addr == `BSZF_ADDR_PAR) || (addr == `BSZF_ADDR_ZFR);
    end
  endfunction

  bszf_tick_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div_sel (cfg_ff[`BSZF_CFG_DIV]),
    .tick_ff (periph_tick)
  );

  assign ton_sample_delay = cfg_ff[`BSZF_CFG_DELAY];
  assign sampling_out_mask = cfg_ff[`BSZF_CFG_MASK];
  assign z_sample_count = zfr_ff[`BSZF_ZFR_COUNT];
  assign d_to_z_blank_len = zfr_ff[`BSZF_ZFR_BLANK];
  assign pwm_rise = pwm_on & ~pwm_prev_ff;
  assign pwm_fall = ~pwm_on & pwm_prev_ff;

  // The delay runs in peripheral ticks from the start of the on-time.
  assign delay_expire = delay_run_ff & periph_tick & (delay_cnt_ff == 8'h01);
  // A delayed sample that ends after the on-time is thrown away.
  assign sample_late = delay_expire & ~pwm_on;

  // Z samples come once per PWM period or on sample clock ticks in the off-time (no delay) or in the on-time after the delay.
  assign z_sample_strobe = (ton_sample_delay == 4'h0) ?
                           (z_sample_at_pwm ? pwm_fall : (sample_clk_tick & ~pwm_on)) :
                           (z_sample_at_pwm ? (delay_expire & pwm_on) :
                            (sample_clk_tick & pwm_on & delay_done_ff));

  assign blanked = (blank_cnt_ff != 10'h000);
  assign z_hit = z_sample_strobe & ~blanked & z_armed_ff & ~d_event;

  // Only the delayed Z sampling path reaches the flag; D sampling never does.
  assign flag_set = sample_late & (ton_sample_delay != 4'h0);

  assign wr_go = aw_have_ff & w_have_ff & ~s_axi_bvalid;
  assign wr_cfg = wr_go & w_strb_ff & (aw_addr_ff == `BSZF_ADDR_CFG);

  always @* begin
    nxt_cfg = cfg_ff;
    if (wr_cfg) begin
      nxt_cfg = {w_data_ff[`BSZF_CFG_DELAY], cfg_ff[`BSZF_CFG_FLAG] & w_data_ff[`BSZF_CFG_FLAG],
                 w_data_ff[`BSZF_CFG_LOW]};
    end
    if (flag_set) begin
      nxt_cfg[`BSZF_CFG_FLAG] = 1'b1;
    end
  end

  always @* begin
    nxt_z_run = z_run_ff;
    if (d_event) begin
      nxt_z_run = 5'h00;
    end else if (z_hit) begin
      if (z_sync_ff) begin
        nxt_z_run = z_run_ff + 5'h01;
      end else begin
        nxt_z_run = 5'h00;
      end
    end
  end

  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `BSZF_RESP_OKAY;
    case (s_axi_araddr)
      `BSZF_ADDR_CFG: nxt_rdata = {24'h00_0000, cfg_ff};
      `BSZF_ADDR_PAR: nxt_rdata = {24'h00_0000, par_ff};
      `BSZF_ADDR_ZFR: nxt_rdata = {24'h00_0000, zfr_ff};
      default: nxt_rresp = `BSZF_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= `BSZF_CFG_RST;
      par_ff <= `BSZF_PAR_RST;
      zfr_ff <= `BSZF_ZFR_RST;
      aw_addr_ff <= 8'h00;
      aw_have_ff <= 1'b0;
      w_data_ff <= 8'h00;
      w_strb_ff <= 1'b0;
      w_have_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BSZF_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `BSZF_RESP_OKAY;
    end else begin
      cfg_ff <= nxt_cfg;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      if (s_axi_awvalid & ~s_axi_awready & ~aw_have_ff) begin
        s_axi_awready <= 1'b1;
        aw_have_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~s_axi_wready & ~w_have_ff) begin
        s_axi_wready <= 1'b1;
        w_have_ff <= 1'b1;
        w_data_ff <= s_axi_wdata[7:0];
        w_strb_ff <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_mapped(aw_addr_ff) ? `BSZF_RESP_OKAY : `BSZF_RESP_SLVERR;
        if (w_strb_ff & (aw_addr_ff == `BSZF_ADDR_PAR)) begin
          par_ff <= w_data_ff;
        end
        if (w_strb_ff & (aw_addr_ff == `BSZF_ADDR_ZFR)) begin
          zfr_ff <= w_data_ff;
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      // The answer follows the address handshake, never the bare request.
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= nxt_rresp;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      z_meta_ff <= 1'b0;
      z_sync_ff <= 1'b0;
      pwm_prev_ff <= 1'b0;
      delay_cnt_ff <= 8'h00;
      delay_run_ff <= 1'b0;
      delay_done_ff <= 1'b0;
      blank_cnt_ff <= 10'h000;
      z_run_ff <= 5'h00;
      z_armed_ff <= 1'b1;
      z_event_ff <= 1'b0;
    end else begin
      z_meta_ff <= z_compare_pin;
      z_sync_ff <= z_meta_ff;
      pwm_prev_ff <= pwm_on;
      if (pwm_rise & (ton_sample_delay != 4'h0)) begin
        delay_cnt_ff <= delay_ticks(ton_sample_delay);
        delay_run_ff <= 1'b1;
        delay_done_ff <= 1'b0;
      end else if (delay_expire) begin
        delay_run_ff <= 1'b0;
        delay_done_ff <= pwm_on;
        delay_cnt_ff <= 8'h00;
      end else begin
        if (delay_run_ff & periph_tick) begin
          delay_cnt_ff <= delay_cnt_ff - 8'h01;
        end
        if (pwm_fall) begin
          delay_done_ff <= 1'b0;
        end
      end
      if (d_event) begin
        blank_cnt_ff <= sensor_mode ? 10'h000 : win_ticks(d_to_z_blank_len);
      end else if (blanked & periph_tick) begin
        blank_cnt_ff <= blank_cnt_ff - 10'h001;
      end
      z_event_ff <= 1'b0;
      if (d_event) begin
        z_armed_ff <= 1'b1;
        z_run_ff <= 5'h00;
      end else if (z_hit & z_sync_ff & (nxt_z_run == {1'b0, z_sample_count} + 5'h01)) begin
        z_event_ff <= 1'b1;
        z_armed_ff <= 1'b0;
        z_run_ff <= 5'h00;
      end else begin
        z_run_ff <= nxt_z_run;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      chan_out_ff <= 6'h00;
      sampling_out_irq_ff <= 1'b0;
      tacho_edge_sel_ff <= `BSZF_TACHO_POSITION;
      speed_sensor_mode_ff <= 1'b0;
      periph_tick_out_ff <= 1'b0;
    end else begin
      if (independent_phase_mode) begin
        chan_out_ff <= chan_drive;
      end else begin
        chan_out_ff <= chan_drive ^ par_ff[`BSZF_PAR_PARITY];
      end
      sampling_out_irq_ff <= nxt_cfg[`BSZF_CFG_FLAG] & nxt_cfg[`BSZF_CFG_MASK];
      tacho_edge_sel_ff <= par_ff[`BSZF_PAR_TACHO];
      speed_sensor_mode_ff <= (par_ff[`BSZF_PAR_TACHO] != `BSZF_TACHO_POSITION);
      periph_tick_out_ff <= periph_tick;
    end
  end
endmodule
`default_nettype wire

/* testbench/bszf_props.sv */
// Port timing checker for the sampling and Z filter block.
`default_nettype none
module bszf_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       d_event,
  input wire logic       sensor_mode,
  input wire logic       independent_phase_mode,
  input wire logic [5:0] chan_drive,
  input wire logic [5:0] chan_out_ff,
  input wire logic       z_event_ff,
  input wire logic       sampling_out_irq_ff,
  input wire logic [1:0] tacho_edge_sel_ff,
  input wire logic       speed_sensor_mode_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  ar_rvalid_a: assert property (s_axi_arready |-> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer out of order");
  par_bypass_a: assert property (independent_phase_mode |=> chan_out_ff == $past(chan_drive))
    else $error("channel not bypassed");
  speed_mode_a: assert property (speed_sensor_mode_ff == (tacho_edge_sel_ff != 2'h0))
    else $error("speed mode wrong");
  z_pulse_a: assert property (z_event_ff |=> !z_event_ff)
    else $error("z event held");
  z_blank_a: assert property (d_event && !sensor_mode |=> !z_event_ff [*8])
    else $error("z event in blanking");
  reset_out_a: assert property (disable iff (1'b0) !aresetn |=> !sampling_out_irq_ff && !s_axi_bvalid)
    else $error("outputs not reset");
endmodule
bind bszf_top bszf_props u_bszf_props (.*);
`default_nettype wire

/* testbench/bszf_motor.sv */
// Power stage model: PWM on-time level and sample clock ticks.
`default_nettype none
module bszf_motor (
  input  wire logic       aclk,
  input  wire logic       run,
  input  wire logic [7:0] on_len,
  output var  logic       pwm_on,
  output var  logic       sample_clk_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cnt_ff;
  logic       run_ff;
  initial begin
    cnt_ff = 8'h00;
    run_ff = 1'b0;
    pwm_on = 1'b0;
    sample_clk_tick = 1'b0;
  end
  // Run is taken only at a period boundary so a stop never cuts an on-time short.
  always @(posedge aclk) begin
    cnt_ff <= (cnt_ff == 8'h27) ? 8'h00 : cnt_ff + 8'h01;
    if (cnt_ff == 8'h27) run_ff <= run;
    pwm_on <= run_ff && (cnt_ff < on_len);
    sample_clk_tick <= (cnt_ff[1:0] == 2'h3);
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the sampling and Z filter block.
`default_nettype none
`include "bszf_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [7:0] a, d, e; logic w; logic [1:0] r;} bszf_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, run;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pwm_on, sample_clk_tick;
  logic z_sample_at_pwm, z_compare_pin, d_event, sensor_mode, independent_phase_mode;
  logic z_event_ff, sampling_out_irq_ff, speed_sensor_mode_ff, periph_tick_out_ff;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, on_len, rv;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, tacho_edge_sel_ff, rs;
  logic [5:0]  chan_drive, chan_out_ff;
  int          err_total, n_compared, cyc, zc, tc;
  bszf_row_t   rows [7] = '{'{`BSZF_ADDR_CFG, 8'h00, 8'h02, 1'b0, `BSZF_RESP_OKAY},
    '{`BSZF_ADDR_PAR, 8'h00, 8'h00, 1'b0, `BSZF_RESP_OKAY}, '{`BSZF_ADDR_ZFR, 8'h00, 8'h0F, 1'b0, `BSZF_RESP_OKAY},
    '{8'h0C, 8'h55, 8'h00, 1'b1, `BSZF_RESP_SLVERR}, '{`BSZF_ADDR_PAR, 8'hC5, 8'hC5, 1'b1, `BSZF_RESP_OKAY},
    '{`BSZF_ADDR_CFG, 8'hFF, 8'hF7, 1'b1, `BSZF_RESP_OKAY}, '{`BSZF_ADDR_ZFR, 8'h30, 8'h30, 1'b1, `BSZF_RESP_OKAY}};
  logic [7:0]  so_cfg [3] = '{8'h10, 8'h04, 8'h14};
  logic [7:0]  so_len [3] = '{8'h14, 8'h05, 8'h05};
  logic [7:0]  so_exp [3] = '{8'h10, 8'h04, 8'h1C};
  bszf_top u_bszf_top (.*);
  bszf_motor u_bszf_motor (.*);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (z_event_ff === 1'b1) zc <= zc + 1;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    {err_total, n_compared, cyc, zc} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, run} = '0;
    {z_sample_at_pwm, z_compare_pin, d_event, sensor_mode, independent_phase_mode} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    chan_drive = 6'h3F;
    on_len = 8'h05;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d, rs);
        chk(32'(rs), 32'(rows[i].r));
      end
      rd(rows[i].a, rv, rs);
      chk(32'(rv), 32'(rows[i].e));
      chk(32'(rs), 32'(rows[i].r));
    end
    for (int k = 0; k < 4; k++) begin
      wr(`BSZF_ADDR_PAR, {k[1:0], 6'h15}, rs);
      repeat (2) @(posedge aclk);
      chk(32'(tacho_edge_sel_ff), 32'(k));
      chk(32'(speed_sensor_mode_ff), 32'(k != 0));
      chk(32'(chan_out_ff), 32'h2A);
    end
    independent_phase_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(chan_out_ff), 32'h3F);
    independent_phase_mode <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(`BSZF_ADDR_CFG, 8'(k), rs);
      repeat (8) @(posedge aclk);
      tc = 0;
      repeat (40) begin
        @(posedge aclk);
        tc += periph_tick_out_ff;
      end
      chk(32'(tc), 32'(40 >> (k == 0 ? 0 : (k == 1 ? 1 : 2))));
    end
    for (int k = 0; k < 3; k++) begin
      wr(`BSZF_ADDR_CFG, so_cfg[k], rs);
      on_len <= so_len[k];
      run <= 1'b1;
      repeat (100) @(posedge aclk);
      run <= 1'b0;
      repeat (60) @(posedge aclk);
      chk(32'(sampling_out_irq_ff), 32'(k == 2));
      rd(`BSZF_ADDR_CFG, rv, rs);
      chk(32'(rv), 32'(so_exp[k]));
    end
    // Mask first, then clear the flag, as software should around a method change.
    wr(`BSZF_ADDR_CFG, 8'h18, rs);
    rd(`BSZF_ADDR_CFG, rv, rs);
    chk(32'(rv), 32'h18);
    chk(32'(sampling_out_irq_ff), 32'h0);
    wr(`BSZF_ADDR_CFG, 8'h10, rs);
    rd(`BSZF_ADDR_CFG, rv, rs);
    chk(32'(rv), 32'h10);
    wr(`BSZF_ADDR_CFG, 8'h00, rs);
    wr(`BSZF_ADDR_ZFR, 8'h31, rs);
    z_compare_pin <= 1'b1;
    d_event <= 1'b1;
    @(posedge aclk);
    d_event <= 1'b0;
    repeat (35) @(posedge aclk);
    chk(32'(zc), 32'h0);
    repeat (40) @(posedge aclk);
    chk(32'(zc), 32'h1);
    z_compare_pin <= 1'b0;
    d_event <= 1'b1;
    @(posedge aclk);
    d_event <= 1'b0;
    repeat (50) @(posedge aclk);
    z_compare_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    z_compare_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(32'(zc), 32'h1);
    z_compare_pin <= 1'b1;
    repeat (40) @(posedge aclk);
    chk(32'(zc), 32'h2);
    // One sample per PWM period; sensor mode must skip the long window.
    wr(`BSZF_ADDR_ZFR, 8'h1F, rs);
    sensor_mode <= 1'b1;
    z_sample_at_pwm <= 1'b1;
    on_len <= 8'h05;
    run <= 1'b1;
    d_event <= 1'b1;
    @(posedge aclk);
    d_event <= 1'b0;
    repeat (40) @(posedge aclk);
    chk(32'(zc), 32'h2);
    repeat (120) @(posedge aclk);
    chk(32'(zc), 32'h3);
    run <= 1'b0;
    // A second reset in mid-run must restore CFG, ZFR and the tacho edge select.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`BSZF_ADDR_CFG, rv, rs);
    chk(32'(rv), 32'(`BSZF_CFG_RST));
    rd(`BSZF_ADDR_ZFR, rv, rs);
    chk(32'(rv), 32'(`BSZF_ZFR_RST));
    chk(32'(tacho_edge_sel_ff), 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
